// ===== hw/apw_defines.vh
// Constants for the host power, reset and watchdog sequencer
//------------------------------------------------------------
// Behaviour
// R1: Outputs high impedance unless a pulse is active
// R2: Pulse ends by releasing line, not driving
// R3: Confirm held 4 s pulses reset 1 s
// R4: After key reset, message, self reset, ignore commands
// R5: Confirm 0.25 s while host off pulses power
// R6: Cancel held 4 s pulses power, extend 5 s
// R7: Blank option blanks display while host down
// R8: Sense source byte: 1 internal, 0 pin 1
// R9: Host rising sense reboots the device
// R10: Mask bits select auto polarity and inversions
// R11: Mask bits enable reset, power-up, power-down keys
// R12: Pulse length in 1/32 s; 255 holds
// R13: Mask and pulse settings saved as boot state
// R14: Host configures general pin drive modes; no pin drive register is implemented here
// R15: Timeout 0 disables; 1..255 arms watchdog
// R16: Watchdog expiry resets host like key reset
// R17: Watchdog off at power-up and after firing
// R18: Readback gives mask and watchdog count
// R19: Accepted command answers with acknowledge code; sense source and save writes leave the acknowledge unchanged
//------------------------------------------------------------
`ifndef APW_DEFINES_VH
`define APW_DEFINES_VH

// Clock and tick arithmetic: 125 MHz, 1/32 second tick
`define APW_CLK_HZ 125000000
// Cycles per tick, 125 MHz / 32, sized to the divider width
`define APW_TICK_DIV 22'd3906250
`define APW_TICK_W 22
// Times in 1/32 second ticks
`define APW_T_LONG_HOLD 8'd128
`define APW_T_SHORT_HOLD 8'd8
`define APW_T_RST_PULSE 8'd32
`define APW_T_EXTEND 8'd160
`define APW_T_SECOND 5'd31
`define APW_PULSE_DEF 8'd32
`define APW_PULSE_HOLD 8'hff

// Function mask bits
`define APW_B_AUTO 0
`define APW_B_RINV 1
`define APW_B_PINV 2
`define APW_B_BLANK 4
`define APW_B_KRST 5
`define APW_B_KPON 6
`define APW_B_KPOFF 7
`define APW_MASK_DEF 8'h00

// Register byte addresses
`define APW_A_MASK 12'h000
`define APW_A_PULSE 12'h004
`define APW_A_SENSE 12'h008
`define APW_A_WDOG 12'h00c
`define APW_A_STAT 12'h010
`define APW_A_ACK 12'h014
`define APW_A_SAVE 12'h018
`define APW_A_KEYS 12'h01c

// Command codes and acknowledge bit
`define APW_CMD_ATX 8'h1c
`define APW_CMD_WDOG 8'h1d
`define APW_ACK_BIT 8'h40

`endif

// ===== hw/apw_tick.v
// Divider making a one-cycle pulse every 1/32 second
`timescale 1ns/1ps
`default_nettype none
`include "apw_defines.vh"
module apw_tick #(
  parameter [`APW_TICK_W-1:0] DIV = `APW_TICK_DIV
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Tick out
  output reg tick_ff
);
  reg [`APW_TICK_W-1:0] cnt_ff; // Cycle counter

  //------------------------------------------------------------
  // Free running divider
  //------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      cnt_ff <= {`APW_TICK_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (cnt_ff == DIV - 1'b1) begin
      cnt_ff <= {`APW_TICK_W{1'b0}};
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/apw_boot.v
// Boot state store for mask, pulse length and sense source
`timescale 1ns/1ps
`default_nettype none
`include "apw_defines.vh"
module apw_boot (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Save port
  input wire save,
  input wire [7:0] mask_in,
  input wire [7:0] pulse_in,
  input wire sense_in,
  // Stored image, registered
  output reg [7:0] mask_ff,
  output reg [7:0] pulse_ff,
  output reg sense_ff
);
  //------------------------------------------------------------
  // Survives soft reboots; only the hard reset loads defaults
  //------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      mask_ff <= `APW_MASK_DEF;
      pulse_ff <= `APW_PULSE_DEF;
      sense_ff <= 1'b1;
    end else if (save) begin // [R13]
      mask_ff <= mask_in;
      pulse_ff <= pulse_in;
      sense_ff <= sense_in;
    end
  end
endmodule
`default_nettype wire

// ===== hw/apw_top.v
// Host power and reset sequencer with watchdog, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "apw_defines.vh"
module apw_top #(
  parameter [`APW_TICK_W-1:0] TICK_DIV = `APW_TICK_DIV
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Keys and sense inputs
  input wire key_confirm,
  input wire key_cancel,
  input wire sense_internal,
  input wire sense_gpio1,
  // Reset and power lines, three signals each
  input wire rst_line_in,
  output reg rst_line_out,
  output reg rst_line_oe,
  input wire pwr_line_in,
  output reg pwr_line_out,
  output reg pwr_line_oe,
  // Display control and device reboot
  output reg display_blank,
  output reg dev_reboot
);
  // State codes, one-hot
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_RST = 5'b00010;
  localparam [4:0] S_PWR = 5'b00100;
  localparam [4:0] S_EXT = 5'b01000;
  localparam [4:0] S_BOOT = 5'b10000;

  wire tick; // 1/32 second enable
  wire [7:0] boot_mask;
  wire [7:0] boot_pulse;
  wire boot_sense;
  reg [7:0] mask_ff; // Live function mask
  reg [7:0] pulse_ff; // Power pulse length
  reg sense_sel_ff; // Sense source select
  reg [7:0] wd_ff; // Watchdog seconds left
  reg [4:0] wd_sub_ff; // Ticks within a second
  reg [7:0] ack_ff; // Last acknowledge code
  reg [4:0] st_ff; // Sequencer state
  reg [7:0] cnt_ff; // Pulse and extension counter
  reg [7:0] hold_ff; // Key hold counter
  reg host_prev_ff; // Sense one cycle back
  reg rst_pol_ff; // Drive level for reset
  reg pwr_pol_ff; // Drive level for power
  reg pwr_holdmode_ff; // Power pulse waits for sense change
  reg pwr_start_sense_ff; // Sense at pulse start
  reg save_ff; // Boot save strobe
  reg wd_fire; // Watchdog expiry this cycle
  reg [31:0] nxt_rdata;

  wire host_up = sense_sel_ff ? sense_internal : sense_gpio1; // [R8]
  wire busy = (st_ff == S_RST) || (st_ff == S_BOOT); // [R4]
  wire wr = psel && penable && pwrite && pready;
  wire rd_setup = psel && !penable;

  apw_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .tick_ff(tick)
  );

  apw_boot u_boot (
    .clock(clock),
    .rst(rst),
    .save(save_ff),
    .mask_in(mask_ff),
    .pulse_in(pulse_ff),
    .sense_in(sense_sel_ff),
    .mask_ff(boot_mask),
    .pulse_ff(boot_pulse),
    .sense_ff(boot_sense)
  );

  //------------------------------------------------------------
  // APB slave: one wait-free access, ready in access phase
  //------------------------------------------------------------
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      `APW_A_MASK: nxt_rdata = {24'h000000, mask_ff}; // [R18]
      `APW_A_PULSE: nxt_rdata = {24'h000000, pulse_ff};
      `APW_A_SENSE: nxt_rdata = {31'h0, sense_sel_ff};
      `APW_A_WDOG: nxt_rdata = {24'h000000, wd_ff}; // [R18]
      `APW_A_STAT: nxt_rdata = {27'h0, st_ff};
      `APW_A_ACK: nxt_rdata = {24'h000000, ack_ff};
      `APW_A_KEYS: nxt_rdata = {28'h0, rst_line_in, pwr_line_in,
                                host_up, busy};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      if (rd_setup) begin
        prdata <= nxt_rdata;
        // Unmapped or write to a status word is an error
        pslverr <= (paddr > `APW_A_KEYS) || (paddr[1:0] != 2'b00)
          || (pwrite && (paddr == `APW_A_STAT
          || paddr == `APW_A_ACK || paddr == `APW_A_KEYS))
          || (pwrite && busy);
      end
    end
  end

  //------------------------------------------------------------
  // Configuration registers; writes refused while busy
  //------------------------------------------------------------
  always @(posedge clock) begin
    if (rst || dev_reboot) begin
      // Reboot reloads the saved boot image
      mask_ff <= rst ? `APW_MASK_DEF : boot_mask; // [R13]
      pulse_ff <= rst ? `APW_PULSE_DEF : boot_pulse;
      sense_sel_ff <= rst ? 1'b1 : boot_sense; // [R8]
      ack_ff <= 8'h00;
      save_ff <= 1'b0;
    end else begin
      save_ff <= 1'b0;
      if (wr && !busy) begin // [R4]
        case (paddr)
          `APW_A_MASK: begin
            mask_ff <= pwdata[7:0];
            ack_ff <= `APW_CMD_ATX | `APW_ACK_BIT; // [R19]
          end
          `APW_A_PULSE: begin
            pulse_ff <= pwdata[7:0]; // [R12]
            ack_ff <= `APW_CMD_ATX | `APW_ACK_BIT; // [R19]
          end
          `APW_A_SENSE: sense_sel_ff <= pwdata[0];
          `APW_A_WDOG: ack_ff <= `APW_CMD_WDOG | `APW_ACK_BIT; // [R19]
          `APW_A_SAVE: save_ff <= pwdata[0]; // [R13]
          default: save_ff <= 1'b0;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // Watchdog: seconds counter, refreshed by each watchdog register write accepted while not busy
  //------------------------------------------------------------
  always @* begin
    wd_fire = (wd_ff == 8'h01) && tick && (wd_sub_ff == `APW_T_SECOND);
  end

  always @(posedge clock) begin
    if (rst || dev_reboot) begin
      wd_ff <= 8'h00; // [R17]
      wd_sub_ff <= 5'd0;
    end else if (wr && !busy && paddr == `APW_A_WDOG) begin
      wd_ff <= pwdata[7:0]; // [R15]
      wd_sub_ff <= 5'd0;
    end else if (wd_fire) begin
      wd_ff <= 8'h00; // [R17]
    end else if (tick && wd_ff != 8'h00) begin
      wd_sub_ff <= wd_sub_ff + 5'd1;
      if (wd_sub_ff == `APW_T_SECOND)
        wd_ff <= wd_ff - 8'h01;
    end
  end

  //------------------------------------------------------------
  // Key hold counter, cleared when the key lets go
  //------------------------------------------------------------
  wire key_any = host_up ? (key_confirm || key_cancel) : key_confirm;
  always @(posedge clock) begin
    if (rst || !key_any || st_ff != S_IDLE) begin
      hold_ff <= 8'h00;
    end else if (tick && hold_ff != 8'hff) begin
      hold_ff <= hold_ff + 8'h01;
    end
  end

  //------------------------------------------------------------
  // Sequencer for pulses, extension and self reboot
  //------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      st_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      // Start from the live sense so a host already up is no edge
      host_prev_ff <= host_up; // [R9]
      rst_pol_ff <= 1'b0;
      pwr_pol_ff <= 1'b0;
      pwr_holdmode_ff <= 1'b0;
      pwr_start_sense_ff <= 1'b0;
      rst_line_oe <= 1'b0;
      rst_line_out <= 1'b0;
      pwr_line_oe <= 1'b0;
      pwr_line_out <= 1'b0;
      dev_reboot <= 1'b0;
      display_blank <= 1'b0;
    end else begin
      host_prev_ff <= host_up;
      dev_reboot <= 1'b0;
      // Blank tracks sense while option set
      display_blank <= mask_ff[`APW_B_BLANK] && !host_up; // [R7]
      if (tick)
        cnt_ff <= cnt_ff + 8'h01;
      case (st_ff)
        S_IDLE: begin
          cnt_ff <= 8'h00;
          // Auto polarity: drive opposite of the idle line level
          rst_pol_ff <= mask_ff[`APW_B_AUTO] ? !rst_line_in
            : mask_ff[`APW_B_RINV]; // [R10]
          pwr_pol_ff <= mask_ff[`APW_B_AUTO] ? !pwr_line_in
            : mask_ff[`APW_B_PINV]; // [R10]
          pwr_holdmode_ff <= (pulse_ff == `APW_PULSE_HOLD); // [R12]
          pwr_start_sense_ff <= host_up;
          if (host_up && !host_prev_ff) begin
            dev_reboot <= 1'b1; // [R9]
          end else if (wd_fire || (host_up && key_confirm
              && mask_ff[`APW_B_KRST]
              && hold_ff == `APW_T_LONG_HOLD)) begin // [R3] [R11] [R16]
            st_ff <= S_RST;
            rst_line_oe <= 1'b1; // [R1]
            rst_line_out <= rst_pol_ff;
          end else if ((!host_up && key_confirm && mask_ff[`APW_B_KPON]
              && hold_ff == `APW_T_SHORT_HOLD) // [R5] [R11]
              || (host_up && key_cancel && mask_ff[`APW_B_KPOFF]
              && hold_ff == `APW_T_LONG_HOLD)) begin // [R6] [R11]
            st_ff <= S_PWR;
            pwr_line_oe <= 1'b1; // [R1]
            pwr_line_out <= pwr_pol_ff;
          end
        end
        S_RST: begin
          if (cnt_ff == `APW_T_RST_PULSE) begin // [R3]
            rst_line_oe <= 1'b0; // [R2]
            rst_line_out <= 1'b0;
            st_ff <= S_BOOT; // [R4]
          end
        end
        S_PWR: begin
          if (pwr_holdmode_ff ? (host_up != pwr_start_sense_ff)
              : (cnt_ff == pulse_ff)) begin // [R12]
            cnt_ff <= 8'h00;
            if (pwr_start_sense_ff && key_cancel && !pwr_holdmode_ff) begin
              st_ff <= S_EXT; // [R6]
            end else begin
              pwr_line_oe <= 1'b0; // [R2]
              pwr_line_out <= 1'b0;
              st_ff <= pwr_start_sense_ff ? S_IDLE : S_BOOT; // [R5]
            end
          end
        end
        S_EXT: begin
          if (!key_cancel || cnt_ff == `APW_T_EXTEND) begin // [R6]
            pwr_line_oe <= 1'b0; // [R2]
            pwr_line_out <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
        S_BOOT: begin
          dev_reboot <= 1'b1; // [R4]
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/apw_monitor.sv
// Port assertions for the power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module apw_monitor #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Host lines
  input wire logic rst_line_out,
  input wire logic rst_line_oe,
  input wire logic pwr_line_oe,
  input wire logic dev_reboot
);
  int rcnt_ff; // Cycles the reset line has been driven
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  //------------------------------
  // Reset drive length
  //------------------------------
  // Restarts whenever the line is released
  always @(posedge clock) begin
    if (rst || !rst_line_oe) begin
      rcnt_ff <= 0;
    end else begin
      rcnt_ff <= rcnt_ff + 1;
    end
  end
  //------------------------------
  // Checks
  //------------------------------
  a_ready_next: assert property (
    psel && !penable |=> pready) else $error("no answer after setup");
  a_unmapped_err: assert property (
    pready && (paddr > 12'h01c || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0) else $error("bad address accepted");
  // Past value used: the decision is taken at the setup edge
  a_busy_refuse: assert property (
    pready && pwrite && $past(rst_line_oe) |-> pslverr)
    else $error("write taken during reset pulse");
  // Tick phase allows one tick of slack either way
  a_reset_len: assert property (
    $fell(rst_line_oe) && !$past(rst) |->
    rcnt_ff >= 31 * TICK_DIV && rcnt_ff <= 33 * TICK_DIV)
    else $error("reset pulse length wrong");
  a_reboot_after: assert property (
    $fell(rst_line_oe) && !$past(rst) |-> ##[0:2] dev_reboot)
    else $error("no reboot after reset pulse");
  a_reboot_once: assert property (
    dev_reboot |=> !dev_reboot) else $error("reboot pulse too long");
  a_level_steady: assert property (
    rst_line_oe && $past(rst_line_oe) |-> $stable(rst_line_out))
    else $error("reset level changed in pulse");
  a_lines_free: assert property (
    $fell(rst) |-> !rst_line_oe && !pwr_line_oe && !dev_reboot)
    else $error("lines driven after reset");
endmodule
bind apw_top apw_monitor #(.TICK_DIV(TICK_DIV)) apw_monitor_i (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rst_line_out(rst_line_out),
  .rst_line_oe(rst_line_oe), .pwr_line_oe(pwr_line_oe),
  .dev_reboot(dev_reboot));
`default_nettype wire

// ===== tb/apw_host_model.sv
// Host board model: pulled-up control lines and supply state
`timescale 1ns/1ps
`default_nettype none
module apw_host_model #(
  parameter int DLY = 3
) (
  // Clock
  input wire logic clock,
  // Device drive
  input wire logic rst_line_out,
  input wire logic rst_line_oe,
  input wire logic pwr_line_out,
  input wire logic pwr_line_oe,
  // Board side
  output logic rst_line_in,
  output logic pwr_line_in,
  output logic host_up
);
  int wait_ff = 0; // Cycles until the supply follows a press
  logic press_ff = 1'b0; // Button seen held last cycle
  // Released lines float to the board pull-up
  assign rst_line_in = rst_line_oe ? rst_line_out : 1'b1;
  assign pwr_line_in = pwr_line_oe ? pwr_line_out : 1'b1;
  // Supply flips a little after the button is let go
  always @(posedge clock) begin
    press_ff <= pwr_line_oe;
    if (press_ff && !pwr_line_oe) begin
      wait_ff <= DLY;
    end else if (wait_ff != 0) begin
      wait_ff <= wait_ff - 1;
      host_up <= host_up ^ (wait_ff == 1);
    end
  end
  initial host_up = 1'b0;
endmodule
`default_nettype wire

// ===== tb/apw_top_tb_top.sv
// Self-checking bench for the power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "apw_defines.vh"
module apw_top_tb_top;
  logic clock, rst, psel, penable, pwrite, key_confirm, sense_gpio1;
  logic key_cancel; // Cancel key, drives the power-off path
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, ri, ro, roe, pi, po, poe, up, blank, rb;
  logic [33:0] aq[$]; // Bus notes: check data, error, data
  logic [9:0] pq[$]; // Pulse notes: line, level, ticks
  logic [33:0] ax;
  logic rlev, plev;
  logic [7:0] p;
  int fail_count, compares, seed, rlen, plen;
  apw_top #(.TICK_DIV(22'd4)) apw_top_i (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_confirm(key_confirm), .key_cancel(key_cancel), .sense_internal(up),
    .sense_gpio1(sense_gpio1), .rst_line_in(ri), .rst_line_out(ro),
    .rst_line_oe(roe), .pwr_line_in(pi), .pwr_line_out(po),
    .pwr_line_oe(poe), .display_blank(blank), .dev_reboot(rb));
  apw_host_model apw_host_model_i (.clock(clock), .rst_line_out(ro),
    .rst_line_oe(roe), .pwr_line_out(po), .pwr_line_oe(poe),
    .rst_line_in(ri), .pwr_line_in(pi), .host_up(up));
  //------------------------------
  // Helpers
  //------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One transfer, then an idle edge so signals never change twice
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int n;
    aq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask
  // Hold one key for n cycles: k high picks the cancel key
  task press(input logic k, input int n);
    if (k) key_cancel <= 1'b1;
    else key_confirm <= 1'b1;
    repeat (n) @(posedge clock);
    key_confirm <= 1'b0;
    key_cancel <= 1'b0;
    @(posedge clock);
  endtask
  task wait_rb(input int n);
    int i;
    i = 0;
    while (rb !== 1'b1 && i < n) begin
      @(posedge clock);
      i++;
    end
    chk("dev_reboot", 1, rb);
    @(posedge clock);
  endtask
  // Pulse width in ticks, rounded to absorb tick phase
  task note(input logic ln, input logic lv, input int len);
    logic [9:0] e;
    if (pq.size() == 0) begin
      chk("unexpected pulse", 0, 1);
    end else begin
      e = pq.pop_front();
      chk("pulse line", e[9], ln);
      chk("pulse level", e[8], lv);
      chk("pulse ticks", e[7:0], (len + 2) / 4);
    end
  endtask
  //------------------------------
  // Result watcher
  //------------------------------
  always @(posedge clock) begin
    if (!rst && psel && penable && pready) begin
      if (aq.size() == 0) begin
        chk("bus answer", 0, 1);
      end else begin
        ax = aq.pop_front();
        chk("pslverr", ax[32], pslverr);
        if (ax[33]) chk("prdata", ax[31:0], prdata);
      end
    end
    if (roe) begin
      rlen <= rlen + 1;
      rlev <= ri;
    end else if (rlen != 0) begin
      note(1'b1, rlev, rlen);
      rlen <= 0;
    end
    if (poe) begin
      plen <= plen + 1;
      plev <= pi;
    end else if (plen != 0) begin
      note(1'b0, plev, plen);
      plen <= 0;
    end
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    final_report;
  end
  //------------------------------
  // Main sequence
  //------------------------------
  initial begin
    {rst, psel, penable, pwrite, key_confirm, sense_gpio1} = 6'b100001;
    key_cancel = 1'b0;
    {paddr, pwdata, rlen, plen, fail_count, compares} = 0;
    seed = 18;
    p = $random(seed);
    p = {2'b00, p[5:0]} + 8'd1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`APW_A_MASK, 32'h0);
    rd(`APW_A_PULSE, 32'd32);
    rd(`APW_A_SENSE, 32'h1);
    rd(`APW_A_WDOG, 32'h0);
    apb(1'b0, 12'h020, 32'h0, {2'b11, 32'h0});
    apb(1'b1, `APW_A_STAT, 32'h1, {2'b01, 32'h0});
    wr(`APW_A_MASK, 32'h50);
    wr(`APW_A_PULSE, {24'h0, p});
    wr(`APW_A_SAVE, 32'h1);
    rd(`APW_A_PULSE, {24'h0, p});
    repeat (8) @(posedge clock);
    chk("display_blank", 1, blank);
    pq.push_back({2'b00, p});
    press(1'b0, 40);
    wait_rb(600);
    repeat (40) @(posedge clock);
    chk("host_up", 1, up);
    chk("display_blank", 0, blank);
    wr(`APW_A_MASK, 32'h22);
    pq.push_back({2'b11, 8'd32});
    press(1'b0, 530);
    apb(1'b1, `APW_A_MASK, 32'h0, {2'b01, 32'h0});
    wait_rb(300);
    rd(`APW_A_MASK, 32'h50);
    // Auto polarity overrides the invert bit: pulled-up line drives low
    wr(`APW_A_MASK, 32'h53);
    wr(`APW_A_WDOG, 32'h1);
    rd(`APW_A_WDOG, 32'h1);
    rd(`APW_A_ACK, 32'h5d);
    pq.push_back({2'b10, 8'd32});
    wait_rb(600);
    rd(`APW_A_WDOG, 32'h0);
    wr(`APW_A_WDOG, 32'h2);
    repeat (200) @(posedge clock);
    wr(`APW_A_WDOG, 32'h2);
    repeat (200) @(posedge clock);
    wr(`APW_A_WDOG, 32'h0);
    repeat (400) @(posedge clock);
    sense_gpio1 <= 1'b0;
    wr(`APW_A_SENSE, 32'h0);
    repeat (8) @(posedge clock);
    chk("display_blank", 1, blank);
    sense_gpio1 <= 1'b1;
    wait_rb(40);
    // Power-off by cancel key held through the full extension
    wr(`APW_A_MASK, 32'h94);
    pq.push_back({2'b01, p + 8'd160});
    press(1'b1, 1500);
    repeat (8) @(posedge clock);
    chk("host_up", 0, up);
    chk("display_blank", 1, blank);
    chk("pulses missing", 0, pq.size());
    final_report;
  end
endmodule
`default_nettype wire
